// ===== logic/ssr_pkg.sv
// Constants, command codes and states of the status reporting bank
package ssr_pkg;

    // ==========================================================
    // Command codes
    localparam logic [4:0] CMD_CLS       = 5'h00;
    localparam logic [4:0] CMD_ESR_Q     = 5'h01;
    localparam logic [4:0] CMD_ESE_W     = 5'h02;
    localparam logic [4:0] CMD_ESE_Q     = 5'h03;
    localparam logic [4:0] CMD_SRE_W     = 5'h04;
    localparam logic [4:0] CMD_SRE_Q     = 5'h05;
    localparam logic [4:0] CMD_STB_Q     = 5'h06;
    localparam logic [4:0] CMD_OPC       = 5'h07;
    localparam logic [4:0] CMD_OPC_Q     = 5'h08;
    localparam logic [4:0] CMD_PSC_W     = 5'h09;
    localparam logic [4:0] CMD_PSC_Q     = 5'h0a;
    localparam logic [4:0] CMD_QCOND_Q   = 5'h0b;
    localparam logic [4:0] CMD_QEVT_Q    = 5'h0c;
    localparam logic [4:0] CMD_QEN_W     = 5'h0d;
    localparam logic [4:0] CMD_QEN_Q     = 5'h0e;
    localparam logic [4:0] CMD_OCOND_Q   = 5'h0f;
    localparam logic [4:0] CMD_OEVT_Q    = 5'h10;
    localparam logic [4:0] CMD_OEN_W     = 5'h11;
    localparam logic [4:0] CMD_OEN_Q     = 5'h12;
    localparam logic [4:0] CMD_PRESET    = 5'h13;
    localparam logic [4:0] CMD_ERR_Q     = 5'h14;

    // ==========================================================
    // Field positions and valid masks
    localparam int         STD_OPC_BIT   = 0;
    localparam int         STD_QUERY_BIT = 2;
    localparam int         STD_DEV_BIT   = 3;
    localparam int         STD_PON_BIT   = 7;
    localparam logic [7:0] STD_VALID     = 8'hbd;
    localparam int         QUES_VOLT_BIT = 0;
    localparam int         QUES_TEMP_BIT = 4;
    localparam int         QUES_OHM_BIT  = 9;
    localparam logic [15:0] QUES_VALID   = 16'h0211;
    localparam int         OPER_FILT_BIT = 8;
    localparam logic [15:0] OPER_VALID   = 16'h0100;
    localparam int         STB_QUES_BIT  = 3;
    localparam int         STB_ESB_BIT   = 5;
    localparam int         STB_OPER_BIT  = 7;

    // ==========================================================
    // Reset values and sizes
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [15:0] RST_WORD     = 16'h0000;
    localparam logic [15:0] OPC_REPLY    = 16'h0001;
    localparam logic [15:0] NO_ERROR     = 16'h0000;
    localparam int          QUEUE_DEPTH  = 20;
    localparam int          ERR_WIDTH    = 16;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b001,
        ST_WAIT_OPC = 3'b010,
        ST_WAIT_OPQ = 3'b100
    } ssr_state_type;

endpackage : ssr_pkg

// ===== logic/ssr_queue_if.sv
// Link between the status bank and its error queue
`timescale 1ns/10ps
`default_nettype none

interface ssr_queue_if #(parameter int WIDTH = 16);
    logic             push;
    logic [WIDTH-1:0] push_data;
    logic             pop;
    logic [WIDTH-1:0] head_data;
    logic             empty;
    logic             full;
    logic             settled;

    modport prod  (output push, push_data, pop, input head_data, empty, full, settled);
    modport store (input push, push_data, pop, output head_data, empty, full, settled);
endinterface : ssr_queue_if

`default_nettype wire

// ===== logic/ssr_err_queue.sv
// First-in first-out store of error codes with registered head
`timescale 1ns/10ps
`default_nettype none

module ssr_err_queue #(
    parameter int DEPTH = 20,
    parameter int WIDTH = 16
) (
    input  wire logic  clk,
    input  wire logic  reset_n,
    input  wire logic  ce,
    ssr_queue_if.store q
);
    localparam int PW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || WIDTH < 1) begin : g_size_chk
        $error("ssr_err_queue: unsupported size");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW-1:0]    count_reg;
    logic [WIDTH-1:0] head_reg;
    logic             changed_reg;
    logic             do_push;
    logic             do_pop;

    // Full queue drops the newcomer
    assign do_push = q.push && !q.full;
    assign do_pop  = q.pop && !q.empty;

    function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
        wrap_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : wrap_inc

    always_ff @(posedge clk) begin
        if (ce && do_push) begin
            mem[wr_ptr_reg] <= q.push_data;
        end
    end

    // Oldest first, read removes it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_reg  <= '0;
            rd_ptr_reg  <= '0;
            count_reg   <= '0;
            changed_reg <= 1'b1;
        end else if (ce) begin
            if (do_push) begin
                wr_ptr_reg <= wrap_inc(wr_ptr_reg);
            end
            if (do_pop) begin
                rd_ptr_reg <= wrap_inc(rd_ptr_reg);
            end
            count_reg   <= count_reg + PW'(do_push) - PW'(do_pop);
            changed_reg <= do_push || do_pop;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            head_reg <= '0;
        end else if (ce) begin
            head_reg <= mem[rd_ptr_reg];
        end
    end

    assign q.head_data = head_reg;
    assign q.empty     = (count_reg == '0);
    assign q.full      = (count_reg == PW'(DEPTH));
    assign q.settled   = !changed_reg;

endmodule : ssr_err_queue

`default_nettype wire

// ===== logic/ssr_status_bank.sv
// Status reporting register bank: event groups, masks, queue and completion
// Operation
// - Standard event register clears on clear-status and on its own query
// - Standard enable mask kept or cleared at power-up per stored setting
// - Reading overload sets standard bit 3 and a questionable event bit
// - Questionable bits 0, 4, 9 flag overloads; others read zero
// - Questionable event register clears on clear-status and on its query
// - Questionable enable clears at power-up, on preset, and writing zero
// - Operational events latch rising (0 to 1) condition changes and stay set until cleared
// - Operational registers use bit 8 only: filter enabled and settled
// - Operational event register clears on clear-status and on its query
// - Operational enable clears at power-up, on preset, and writing zero
// - Error queue holds twenty entries, returned oldest first, removed on read
// - Every query returns the register as its binary weighted value
// - Enable masks select which event bits reach the summary bits
// - Clear-status clears summary and event registers, never the masks
// - Completion command sets bit 0 after all earlier work finished
// - Completion query answers one only after earlier work finished
// - Power-on-clear setting stored nonvolatile, readable, clears masks when one
// - Status byte enable mask writable and readable back
// - Standard bits 1 and 6 read zero; bit 7 marks power cycle
// - Error bits 2 to 5 also enqueue an error, except reading overload
`timescale 1ns/10ps
`default_nettype none

module ssr_status_bank #(
    parameter int QDEPTH = ssr_pkg::QUEUE_DEPTH,
    parameter int EWIDTH = ssr_pkg::ERR_WIDTH
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              ce,
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire logic [4:0]        cmd_code,
    input  wire logic [15:0]       cmd_data,
    output logic                   rsp_valid,
    output logic [15:0]            rsp_data,
    input  wire logic              ops_pending,
    input  wire logic              meas_done,
    input  wire logic              ovl_volt,
    input  wire logic              ovl_temp,
    input  wire logic              ovl_ohm,
    input  wire logic              filter_on,
    input  wire logic              filter_settled,
    input  wire logic              err_push,
    input  wire logic [1:0]        err_class,
    input  wire logic [EWIDTH-1:0] err_code,
    input  wire logic              nv_psc_in,
    input  wire logic [7:0]        nv_ese_in,
    input  wire logic [7:0]        nv_sre_in,
    output logic                   nv_psc_out,
    output logic [7:0]             nv_ese_out,
    output logic [7:0]             nv_sre_out,
    output logic [7:0]             status_byte
);
    if (EWIDTH < 16 || QDEPTH < 2) begin : g_size_chk
        $error("ssr_status_bank: unsupported size");
    end

    // ==========================================================
    // Storage
    ssr_pkg::ssr_state_type state_reg;
    logic        init_reg;
    logic        psc_reg;
    logic [7:0]  std_reg;
    logic [7:0]  ese_reg;
    logic [7:0]  sre_reg;
    logic [15:0] qcond_reg;
    logic [15:0] qevt_reg;
    logic [15:0] qen_reg;
    logic [15:0] ocond_reg;
    logic [15:0] oevt_reg;
    logic [15:0] oen_reg;
    logic [7:0]  stb_reg;
    logic        take;
    logic        std_clr;
    logic        q_clr;
    logic        o_clr;
    logic        preset;
    logic        opc_done;
    logic        any_ovl;
    logic [7:0]  std_set;
    logic [15:0] qcond_next;
    logic [15:0] ocond_next;
    logic [15:0] oevt_set;

    ssr_queue_if #(.WIDTH(EWIDTH)) eq ();

    ssr_err_queue #(.DEPTH(QDEPTH), .WIDTH(EWIDTH)) u_queue (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce),
        .q       (eq)
    );

    // ==========================================================
    // Command decode
    assign cmd_ready = (state_reg == ssr_pkg::ST_IDLE) && !init_reg && eq.settled;
    assign take      = ce && cmd_valid && cmd_ready;
    assign std_clr   = take && (cmd_code == ssr_pkg::CMD_CLS || cmd_code == ssr_pkg::CMD_ESR_Q);
    assign q_clr     = take && (cmd_code == ssr_pkg::CMD_CLS || cmd_code == ssr_pkg::CMD_QEVT_Q);
    assign o_clr     = take && (cmd_code == ssr_pkg::CMD_CLS || cmd_code == ssr_pkg::CMD_OEVT_Q);
    assign preset    = take && (cmd_code == ssr_pkg::CMD_PRESET);
    assign opc_done  = (state_reg == ssr_pkg::ST_WAIT_OPC) && !ops_pending;
    assign any_ovl   = meas_done && (ovl_volt || ovl_temp || ovl_ohm);

    // Error to queue; overload never enqueues
    assign eq.push      = ce && err_push;
    assign eq.push_data = err_code;
    assign eq.pop       = take && (cmd_code == ssr_pkg::CMD_ERR_Q);

    // ==========================================================
    // Completion sequencing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ssr_pkg::ST_IDLE;
        end else if (ce) begin
            unique case (state_reg)
                ssr_pkg::ST_IDLE: begin
                    if (take && cmd_code == ssr_pkg::CMD_OPC) begin
                        state_reg <= ssr_pkg::ST_WAIT_OPC;
                    end else if (take && cmd_code == ssr_pkg::CMD_OPC_Q) begin
                        state_reg <= ssr_pkg::ST_WAIT_OPQ;
                    end
                end
                ssr_pkg::ST_WAIT_OPC: begin
                    if (!ops_pending) begin
                        state_reg <= ssr_pkg::ST_IDLE;
                    end
                end
                ssr_pkg::ST_WAIT_OPQ: begin
                    if (!ops_pending) begin
                        state_reg <= ssr_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ssr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Power-up load of masks and setting
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            init_reg <= 1'b1;
            psc_reg  <= 1'b0;
            ese_reg  <= ssr_pkg::RST_BYTE;
            sre_reg  <= ssr_pkg::RST_BYTE;
        end else if (ce) begin
            init_reg <= 1'b0;
            if (init_reg) begin
                psc_reg <= nv_psc_in;
                ese_reg <= nv_psc_in ? ssr_pkg::RST_BYTE : nv_ese_in;
                sre_reg <= nv_psc_in ? ssr_pkg::RST_BYTE : nv_sre_in;
            end else if (take) begin
                if (cmd_code == ssr_pkg::CMD_PSC_W) begin
                    psc_reg <= cmd_data[0];
                end
                if (cmd_code == ssr_pkg::CMD_ESE_W) begin
                    ese_reg <= cmd_data[7:0];
                end
                if (cmd_code == ssr_pkg::CMD_SRE_W) begin
                    sre_reg <= cmd_data[7:0];
                end
            end
        end
    end

    // Questionable and operational masks clear at power-up
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            qen_reg <= ssr_pkg::RST_WORD;
            oen_reg <= ssr_pkg::RST_WORD;
        end else if (ce) begin
            if (preset) begin
                qen_reg <= ssr_pkg::RST_WORD;
                oen_reg <= ssr_pkg::RST_WORD;
            end else if (take && cmd_code == ssr_pkg::CMD_QEN_W) begin
                qen_reg <= cmd_data;
            end else if (take && cmd_code == ssr_pkg::CMD_OEN_W) begin
                oen_reg <= cmd_data;
            end
        end
    end

    // ==========================================================
    // Standard event register, set wins over clear
    always_comb begin
        std_set                       = 8'h00;
        std_set[ssr_pkg::STD_OPC_BIT] = opc_done;
        std_set[ssr_pkg::STD_PON_BIT] = init_reg;
        if (err_push) begin
            std_set[ssr_pkg::STD_QUERY_BIT + int'(err_class)] = 1'b1;
        end
        if (any_ovl) begin
            std_set[ssr_pkg::STD_DEV_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            std_reg <= ssr_pkg::RST_BYTE;
        end else if (ce) begin
            std_reg <= ((std_clr ? 8'h00 : std_reg) | std_set) & ssr_pkg::STD_VALID;
        end
    end

    // ==========================================================
    // Questionable and operational groups
    always_comb begin
        qcond_next                          = qcond_reg;
        ocond_next                          = ocond_reg;
        if (meas_done) begin
            qcond_next                          = 16'h0000;
            qcond_next[ssr_pkg::QUES_VOLT_BIT]  = ovl_volt;
            qcond_next[ssr_pkg::QUES_TEMP_BIT]  = ovl_temp;
            qcond_next[ssr_pkg::QUES_OHM_BIT]   = ovl_ohm;
            ocond_next                          = 16'h0000;
            ocond_next[ssr_pkg::OPER_FILT_BIT]  = filter_on && filter_settled;
        end
        oevt_set = ocond_next & ~ocond_reg & ssr_pkg::OPER_VALID;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            qcond_reg <= ssr_pkg::RST_WORD;
            ocond_reg <= ssr_pkg::RST_WORD;
            qevt_reg  <= ssr_pkg::RST_WORD;
            oevt_reg  <= ssr_pkg::RST_WORD;
        end else if (ce) begin
            qcond_reg <= qcond_next & ssr_pkg::QUES_VALID;
            ocond_reg <= ocond_next & ssr_pkg::OPER_VALID;
            qevt_reg  <= ((q_clr ? 16'h0000 : qevt_reg)
                          | (meas_done ? qcond_next : 16'h0000)) & ssr_pkg::QUES_VALID;
            oevt_reg  <= (o_clr ? 16'h0000 : oevt_reg) | oevt_set;
        end
    end

    // Summary bits from events gated by masks
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stb_reg <= ssr_pkg::RST_BYTE;
        end else if (ce) begin
            stb_reg                        <= 8'h00;
            stb_reg[ssr_pkg::STB_QUES_BIT] <= |(qevt_reg & qen_reg);
            stb_reg[ssr_pkg::STB_ESB_BIT]  <= |(std_reg & ese_reg);
            stb_reg[ssr_pkg::STB_OPER_BIT] <= |(oevt_reg & oen_reg);
        end
    end

    // ==========================================================
    // Answers, each the plain weighted value
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
            rsp_data  <= ssr_pkg::RST_WORD;
        end else if (ce) begin
            rsp_valid <= 1'b0;
            if (state_reg == ssr_pkg::ST_WAIT_OPQ && !ops_pending) begin
                rsp_valid <= 1'b1;
                rsp_data  <= ssr_pkg::OPC_REPLY;
            end else if (take) begin
                rsp_valid <= 1'b1;
                unique case (cmd_code)
                    ssr_pkg::CMD_ESR_Q:   rsp_data <= {8'h00, std_reg};
                    ssr_pkg::CMD_ESE_Q:   rsp_data <= {8'h00, ese_reg};
                    ssr_pkg::CMD_SRE_Q:   rsp_data <= {8'h00, sre_reg};
                    ssr_pkg::CMD_STB_Q:   rsp_data <= {8'h00, stb_reg};
                    ssr_pkg::CMD_PSC_Q:   rsp_data <= {15'h0000, psc_reg};
                    ssr_pkg::CMD_QCOND_Q: rsp_data <= qcond_reg;
                    ssr_pkg::CMD_QEVT_Q:  rsp_data <= qevt_reg;
                    ssr_pkg::CMD_QEN_Q:   rsp_data <= qen_reg;
                    ssr_pkg::CMD_OCOND_Q: rsp_data <= ocond_reg;
                    ssr_pkg::CMD_OEVT_Q:  rsp_data <= oevt_reg;
                    ssr_pkg::CMD_OEN_Q:   rsp_data <= oen_reg;
                    ssr_pkg::CMD_ERR_Q:   rsp_data <= eq.empty ? ssr_pkg::NO_ERROR
                                                               : eq.head_data[15:0];
                    default: begin
                        rsp_valid <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign nv_psc_out  = psc_reg;
    assign nv_ese_out  = ese_reg;
    assign nv_sre_out  = sre_reg;
    assign status_byte = stb_reg;

    // ==========================================================
    // Checks
    sequence s_opcq_taken;
        take && cmd_code == ssr_pkg::CMD_OPC_Q;
    endsequence

    sequence s_opcq_wait;
        (state_reg == ssr_pkg::ST_WAIT_OPQ) && ops_pending;
    endsequence

    std_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
        std_clr |=> std_reg == ($past(std_set) & ssr_pkg::STD_VALID))
        else $error("standard event not cleared");
    psc_power_a: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && init_reg && nv_psc_in) |=> (ese_reg == 8'h00 && sre_reg == 8'h00))
        else $error("masks not cleared at power-up");
    ovl_both_a: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && any_ovl) |=> std_reg[ssr_pkg::STD_DEV_BIT] && (qevt_reg != 16'h0000))
        else $error("overload not reported in both groups");
    ques_bits_a: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && meas_done) |=> qcond_reg == {6'h00, $past(ovl_ohm), 4'h0, $past(ovl_temp), 3'h0, $past(ovl_volt)})
        else $error("questionable condition wrong");
    oper_sticky_a: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && oevt_reg[ssr_pkg::OPER_FILT_BIT] && !o_clr) |=> oevt_reg[ssr_pkg::OPER_FILT_BIT])
        else $error("operational event lost");
    preset_masks_a: assert property (@(posedge clk) disable iff (!reset_n)
        preset |=> (qen_reg == 16'h0000 && oen_reg == 16'h0000))
        else $error("preset left masks set");
    opcq_reply_a: assert property (@(posedge clk) disable iff (!reset_n)
        s_opcq_taken ##1 s_opcq_wait |-> !rsp_valid)
        else $error("early completion reply");
    opc_bit_a: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && opc_done) |=> std_reg[ssr_pkg::STD_OPC_BIT])
        else $error("completion bit not set");
    summary_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce |=> status_byte[ssr_pkg::STB_ESB_BIT] == $past(|(std_reg & ese_reg)))
        else $error("summary bit wrong");

endmodule : ssr_status_bank

`default_nettype wire

// ===== logic/dummy_unused.sv
// Empty file
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ===== verif/ssr_host_model.sv
// Remote controller model that issues status commands and collects answers
`timescale 1ns/10ps
`default_nettype none

module ssr_host_model (
    input  wire logic        clk,
    input  wire logic        cmd_ready,
    input  wire logic        rsp_valid,
    input  wire logic [15:0] rsp_data,
    output logic             cmd_valid,
    output logic [4:0]       cmd_code,
    output logic [15:0]      cmd_data
);
    // ==========================================================
    // Command transfer
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 5'h00;
        cmd_data = 16'h0000;
    end

    task xfer(input logic [4:0] c, input logic [15:0] d, input bit want,
              output logic [15:0] r, output bit ok);
        int n;
        r = 16'h0000;
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_data = d;
        for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        cmd_data = ~d;
        ok = (n < 50);
        if (want && ok) begin
            for (n = 0; n < 100 && rsp_valid !== 1'b1; n++) begin
                @(posedge clk);
                #1;
            end
            ok = (rsp_valid === 1'b1);
            r = rsp_data;
        end
    endtask : xfer
endmodule : ssr_host_model

`default_nettype wire

// ===== verif/ssr_status_bank_tb.sv
// Self-checking bench of the status reporting bank
`timescale 1ns/10ps
`default_nettype none

module ssr_status_bank_tb;
    logic        clk, reset_n, ce, ops_pending, meas_done, err_push, nv_psc_in;
    logic        ovl_volt, ovl_temp, ovl_ohm, filter_on, filter_settled, nv_psc_o;
    logic        cmd_valid, cmd_ready, rsp_valid;
    logic [1:0]  err_class;
    logic [4:0]  cmd_code;
    logic [7:0]  nv_ese_in, nv_sre_in, status_byte, nv_sre_o;
    logic [15:0] err_code, cmd_data, rsp_data;
    int          failures = 0;
    int          checked = 0;

    ssr_status_bank i_ssr_status_bank (.clk, .reset_n, .ce, .cmd_valid, .cmd_ready,
        .cmd_code, .cmd_data, .rsp_valid, .rsp_data, .ops_pending, .meas_done,
        .ovl_volt, .ovl_temp, .ovl_ohm, .filter_on, .filter_settled, .err_push,
        .err_class, .err_code, .nv_psc_in, .nv_ese_in, .nv_sre_in, .nv_psc_out(nv_psc_o),
        .nv_ese_out(), .nv_sre_out(nv_sre_o), .status_byte);
    ssr_host_model i_ssr_host_model (.clk, .cmd_ready, .rsp_valid, .rsp_data,
        .cmd_valid, .cmd_code, .cmd_data);

    // ==========================================================
    // Shared tasks
    task final_report();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    task chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task cmd(input logic [4:0] c, input logic [15:0] d, input bit want,
             input logic [15:0] e);
        logic [15:0] r;
        bit          ok;
        i_ssr_host_model.xfer(c, d, want, r, ok);
        if (!ok) begin
            failures++;
            final_report();
        end
        if (want) chk(r, e);
    endtask : cmd

    task pwr(input logic p, input logic [7:0] e, input logic [7:0] s);
        reset_n = 1'b0;
        nv_psc_in = p;
        nv_ese_in = e;
        nv_sre_in = s;
        repeat (10) @(posedge clk);
        #1;
        reset_n = 1'b1;
    endtask : pwr

    // Order: volt, temp, ohm, filter on, filter settled
    task meas(input logic [4:0] m);
        @(posedge clk);
        #1;
        {ovl_volt, ovl_temp, ovl_ohm, filter_on, filter_settled} = m;
        meas_done = 1'b1;
        @(posedge clk);
        #1;
        meas_done = 1'b0;
    endtask : meas

    task push(input logic [1:0] c, input logic [15:0] d);
        @(posedge clk);
        #1;
        err_push = 1'b1;
        err_class = c;
        err_code = d;
        @(posedge clk);
        #1;
        err_push = 1'b0;
    endtask : push

    // ==========================================================
    // Scenarios
    task s_power();
        pwr(1'b1, 8'hff, 8'hff);
        cmd(ssr_pkg::CMD_ESE_Q, 16'h0, 1, 16'h0000);
        cmd(ssr_pkg::CMD_SRE_Q, 16'h0, 1, 16'h0000);
        cmd(ssr_pkg::CMD_PSC_Q, 16'h0, 1, 16'h0001);
        cmd(ssr_pkg::CMD_QEN_Q, 16'h0, 1, 16'h0000);
        cmd(ssr_pkg::CMD_ESR_Q, 16'h0, 1, 16'h0080);
        cmd(ssr_pkg::CMD_ESR_Q, 16'h0, 1, 16'h0000);
        cmd(ssr_pkg::CMD_SRE_W, 16'ha5, 0, 16'h0);
        cmd(ssr_pkg::CMD_SRE_Q, 16'h0, 1, 16'h00a5);
        cmd(ssr_pkg::CMD_ESE_W, 16'h3c, 0, 16'h0);
        cmd(ssr_pkg::CMD_ESE_W, 16'h0, 0, 16'h0);
        cmd(ssr_pkg::CMD_ESE_Q, 16'h0, 1, 16'h0000);
        cmd(ssr_pkg::CMD_OEN_W, 16'h0100, 0, 16'h0);
        cmd(ssr_pkg::CMD_PRESET, 16'h0, 0, 16'h0);
        cmd(ssr_pkg::CMD_OEN_Q, 16'h0, 1, 16'h0000);
    endtask : s_power

    task s_ovl();
        cmd(ssr_pkg::CMD_QEN_W, 16'h0211, 0, 16'h0);
        meas(5'h1c);
        cmd(ssr_pkg::CMD_QCOND_Q, 16'h0, 1, 16'h0211);
        chk({8'h00, status_byte}, 16'h0008);
        cmd(ssr_pkg::CMD_STB_Q, 16'h0, 1, 16'h0008);
        cmd(ssr_pkg::CMD_ESR_Q, 16'h0, 1, 16'h0008);
        cmd(ssr_pkg::CMD_ERR_Q, 16'h0, 1, 16'h0000);
        cmd(ssr_pkg::CMD_QEVT_Q, 16'h0, 1, 16'h0211);
        cmd(ssr_pkg::CMD_QEVT_Q, 16'h0, 1, 16'h0000);
        meas(5'h1c);
        meas(5'h00);
        cmd(ssr_pkg::CMD_CLS, 16'h0, 0, 16'h0);
        repeat (3) @(posedge clk);
        #1;
        chk({8'h00, status_byte}, 16'h0000);
        cmd(ssr_pkg::CMD_QEVT_Q, 16'h0, 1, 16'h0000);
        cmd(ssr_pkg::CMD_ESR_Q, 16'h0, 1, 16'h0000);
        cmd(ssr_pkg::CMD_QEN_Q, 16'h0, 1, 16'h0211);
        cmd(ssr_pkg::CMD_PRESET, 16'h0, 0, 16'h0);
        cmd(ssr_pkg::CMD_QEN_Q, 16'h0, 1, 16'h0000);
    endtask : s_ovl

    task s_oper();
        meas(5'h03);
        cmd(ssr_pkg::CMD_OCOND_Q, 16'h0, 1, 16'h0100);
        meas(5'h02);
        cmd(ssr_pkg::CMD_OCOND_Q, 16'h0, 1, 16'h0000);
        cmd(ssr_pkg::CMD_OEVT_Q, 16'h0, 1, 16'h0100);
        cmd(ssr_pkg::CMD_OEVT_Q, 16'h0, 1, 16'h0000);
        meas(5'h00);
        meas(5'h03);
        cmd(ssr_pkg::CMD_CLS, 16'h0, 0, 16'h0);
        cmd(ssr_pkg::CMD_OEVT_Q, 16'h0, 1, 16'h0000);
    endtask : s_oper

    task s_opc();
        time t, tr;
        ops_pending = 1'b1;
        fork
            begin
                cmd(ssr_pkg::CMD_OPC_Q, 16'h0, 1, 16'h0001);
                tr = $time;
            end
            begin
                repeat (6) @(posedge clk);
                #1;
                ops_pending = 1'b0;
                t = $time;
            end
        join
        chk({15'h0000, tr > t}, 16'h0001);
        ops_pending = 1'b1;
        fork
            begin
                cmd(ssr_pkg::CMD_OPC, 16'h0, 0, 16'h0);
                cmd(ssr_pkg::CMD_ESR_Q, 16'h0, 1, 16'h0001);
            end
            begin
                repeat (6) @(posedge clk);
                #1;
                ops_pending = 1'b0;
            end
        join
    endtask : s_opc

    task s_err();
        for (int i = 0; i < 4; i++) begin
            push(i[1:0], 16'h00a0 + 16'(i));
            cmd(ssr_pkg::CMD_ESR_Q, 16'h0, 1, 16'h0004 << i);
            cmd(ssr_pkg::CMD_ERR_Q, 16'h0, 1, 16'h00a0 + 16'(i));
        end
        for (int i = 0; i <= ssr_pkg::QUEUE_DEPTH; i++) push(2'h2, 16'(i + 1));
        for (int i = 0; i <= ssr_pkg::QUEUE_DEPTH; i++) begin
            cmd(ssr_pkg::CMD_ERR_Q, 16'h0, 1,
                (i < ssr_pkg::QUEUE_DEPTH) ? 16'(i + 1) : 16'h0000);
        end
        cmd(ssr_pkg::CMD_PSC_W, 16'h0, 0, 16'h0);
        cmd(ssr_pkg::CMD_OEN_W, 16'h0100, 0, 16'h0);
        chk({7'h0, nv_psc_o, nv_sre_o}, 16'h00a5);
        pwr(1'b0, 8'h21, 8'h5a);
        cmd(ssr_pkg::CMD_ESE_Q, 16'h0, 1, 16'h0021);
        cmd(ssr_pkg::CMD_SRE_Q, 16'h0, 1, 16'h005a);
        cmd(ssr_pkg::CMD_PSC_Q, 16'h0, 1, 16'h0000);
        cmd(ssr_pkg::CMD_OEN_Q, 16'h0, 1, 16'h0000);
    endtask : s_err

    // ==========================================================
    // Clock and main sequence
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        {ce, ops_pending, meas_done, err_push, err_class, err_code} = '0;
        {ovl_volt, ovl_temp, ovl_ohm, filter_on, filter_settled} = '0;
        ce = 1'b1;
        s_power();
        s_ovl();
        s_oper();
        s_opc();
        s_err();
        final_report();
    end
endmodule : ssr_status_bank_tb

`default_nettype wire
